/* core/bmrr_cfg.svh */
// constants for the boot mode and running reset block
`ifndef BMRR_CFG_SVH
`define BMRR_CFG_SVH
`define BMRR_CFG3_SPI_SLAVE 3'h0
`define BMRR_CFG3_SPI_MASTER 3'h1
`define BMRR_CFG3_FLASH 3'h2
`define BMRR_CFG3_NO_BOOT 3'h3
`define BMRR_CFG2_SPI_SLAVE 2'h0
`define BMRR_CFG2_SPI_MASTER 2'h1
`define BMRR_CFG2_RESERVED 2'h2
`define BMRR_CFG2_NO_BOOT 2'h3
`define BMRR_PKG_LARGE 1'h1
`define BMRR_RUN_RST_NS 100
`define BMRR_CLK_NS 50
`define BMRR_RUN_RST_CYC ((`BMRR_RUN_RST_NS + `BMRR_CLK_NS - 1) / `BMRR_CLK_NS)
`define BMRR_RUN_RST_W 4
`endif

/* core/bmrr_pkg.sv */
// types for the boot mode and running reset block
package bmrr_pkg;
  typedef enum logic [2:0] {
    BMRR_SRC_SPI_SLAVE = 3'h0,
    BMRR_SRC_SPI_MASTER = 3'h1,
    BMRR_SRC_FLASH = 3'h2,
    BMRR_SRC_NONE = 3'h3,
    BMRR_SRC_RESERVED = 3'h4
  } bmrr_src_e;
  typedef enum logic [1:0] {
    BMRR_ST_LATCH = 2'h0,
    BMRR_ST_BOOT = 2'h1,
    BMRR_ST_RUN = 2'h2,
    BMRR_ST_RUN_RST = 2'h3
  } bmrr_state_e;
endpackage

/* core/bmrr_decode.sv */
// boot-select pin decoder for both package options
`timescale 1ns/1ns
`include "bmrr_cfg.svh"
module bmrr_decode
  import bmrr_pkg::*;
(
  input wire logic pkg_large,
  input wire logic [2:0] boot_select_pins_three,
  input wire logic [1:0] boot_select_pins_two,
  output bmrr_src_e src
);
  wire bmrr_src_e src_three;
  wire bmrr_src_e src_two;
  assign src_three = boot_select_pins_three[2] ? BMRR_SRC_RESERVED :
                     (boot_select_pins_three == `BMRR_CFG3_SPI_SLAVE) ? BMRR_SRC_SPI_SLAVE :
                     (boot_select_pins_three == `BMRR_CFG3_SPI_MASTER) ? BMRR_SRC_SPI_MASTER :
                     (boot_select_pins_three == `BMRR_CFG3_FLASH) ? BMRR_SRC_FLASH : BMRR_SRC_NONE;
  assign src_two = (boot_select_pins_two == `BMRR_CFG2_SPI_SLAVE) ? BMRR_SRC_SPI_SLAVE :
                   (boot_select_pins_two == `BMRR_CFG2_SPI_MASTER) ? BMRR_SRC_SPI_MASTER :
                   (boot_select_pins_two == `BMRR_CFG2_RESERVED) ? BMRR_SRC_RESERVED : BMRR_SRC_NONE;
  assign src = (pkg_large == `BMRR_PKG_LARGE) ? src_three : src_two;
endmodule // bmrr_decode

/* core/bmrr_top.sv */
// boot mode selection and running reset control
`timescale 1ns/1ns
`include "bmrr_cfg.svh"
module bmrr_top
  import bmrr_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pkg_large,
  input wire logic [2:0] boot_select_pins_three,
  input wire logic [1:0] boot_select_pins_two,
  input wire logic boot_done,
  input wire logic reset_out_running_reset_in_i,
  output logic reset_out_running_reset_in_o,
  output logic reset_out_running_reset_in_oe,
  output logic [2:0] boot_source,
  output logic boot_start,
  output logic boot_reserved,
  output logic rom_exec,
  output logic core_rst_n,
  output logic periph_rst_n,
  output logic pll_rst_n,
  output logic sdram_rst_n
);
  bmrr_state_e state_q, state_d;
  bmrr_src_e src_q;
  bmrr_src_e src_dec;
  logic [`BMRR_RUN_RST_W-1:0] cnt_q;
  logic pin_q;
  logic boot_start_q;
  logic run_req;
  logic cnt_done;

  // only these sources need a loader run; none and reserved go straight to run, and only none runs from rom
  function automatic logic src_loads(input bmrr_src_e s);
    return (s == BMRR_SRC_SPI_SLAVE) || (s == BMRR_SRC_SPI_MASTER) || (s == BMRR_SRC_FLASH);
  endfunction

  bmrr_decode u_dec (
    .pkg_large(pkg_large),
    .boot_select_pins_three(boot_select_pins_three),
    .boot_select_pins_two(boot_select_pins_two),
    .src(src_dec)
  );

  // pad read low while we drive it high
  assign run_req = (state_q == BMRR_ST_RUN) && pin_q && !reset_out_running_reset_in_i;
  assign cnt_done = (cnt_q == `BMRR_RUN_RST_W'(`BMRR_RUN_RST_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      BMRR_ST_LATCH: begin
        // no boot goes straight to rom
        if (src_loads(src_dec)) begin
          state_d = BMRR_ST_BOOT;
        end else begin
          state_d = BMRR_ST_RUN;
        end
      end
      BMRR_ST_BOOT: if (boot_done) begin
        state_d = BMRR_ST_RUN;
      end
      BMRR_ST_RUN: if (run_req) begin
        state_d = BMRR_ST_RUN_RST;
      end
      // back to run, never to boot
      BMRR_ST_RUN_RST: if (cnt_done) begin
        state_d = BMRR_ST_RUN;
      end
      default: state_d = BMRR_ST_LATCH;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= BMRR_ST_LATCH;
      src_q <= BMRR_SRC_NONE;
      cnt_q <= '0;
      pin_q <= 1'b0;
      boot_start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      boot_start_q <= (state_q == BMRR_ST_LATCH) && (state_d == BMRR_ST_BOOT);
      pin_q <= (state_d == BMRR_ST_RUN);
      if (state_q == BMRR_ST_LATCH) begin
        src_q <= src_dec;
      end
      cnt_q <= (state_q == BMRR_ST_RUN_RST) ? cnt_q + 1'b1 : '0;
    end
  end

  // reset-out drives high while running; output enable off otherwise so the pad can be pulled
  assign reset_out_running_reset_in_o = 1'b1;
  assign reset_out_running_reset_in_oe = pin_q;
  assign boot_source = src_q;
  assign boot_start = boot_start_q;
  assign boot_reserved = (src_q == BMRR_SRC_RESERVED);
  assign rom_exec = (src_q == BMRR_SRC_NONE) && (state_q == BMRR_ST_RUN);
  assign core_rst_n = (state_q == BMRR_ST_RUN);
  assign periph_rst_n = (state_q != BMRR_ST_LATCH) && (state_q != BMRR_ST_RUN_RST);
  assign pll_rst_n = 1'b1;
  assign sdram_rst_n = (state_q != BMRR_ST_LATCH);

  AST_RUN_NO_BOOT: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_RUN_RST |=> state_q != BMRR_ST_BOOT && !boot_start)
    else $error("running reset started a boot");
  AST_RUN_KEEPS_SDRAM: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_RUN_RST |-> sdram_rst_n && pll_rst_n && !core_rst_n && !periph_rst_n)
    else $error("running reset domains wrong");
  AST_PIN_REQ: assert property (@(posedge core_clk) disable iff (!nrst)
    run_req |=> state_q == BMRR_ST_RUN_RST ##2 state_q == BMRR_ST_RUN)
    else $error("running reset request not served");
  AST_NOBOOT_ROM: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_LATCH && src_dec == BMRR_SRC_NONE |=> rom_exec && !boot_start)
    else $error("no boot did not run from rom");
  AST_BOOT_START: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_LATCH && src_dec inside {BMRR_SRC_SPI_SLAVE, BMRR_SRC_SPI_MASTER, BMRR_SRC_FLASH}
    |=> boot_start && boot_source == $past(src_dec) ##1 !boot_start)
    else $error("boot not started");
  AST_LARGE_FLASH: assert property (@(posedge core_clk) disable iff (!nrst)
    pkg_large && boot_select_pins_three == 3'h2 |-> src_dec == BMRR_SRC_FLASH)
    else $error("flash code misdecoded");
  AST_LARGE_RSVD: assert property (@(posedge core_clk) disable iff (!nrst)
    pkg_large && boot_select_pins_three[2] |-> src_dec == BMRR_SRC_RESERVED)
    else $error("reserved code misdecoded");
  AST_SMALL_CODES: assert property (@(posedge core_clk) disable iff (!nrst)
    !pkg_large |-> (boot_select_pins_two == 2'h2) == (src_dec == BMRR_SRC_RESERVED)
    && (boot_select_pins_two == 2'h3) == (src_dec == BMRR_SRC_NONE))
    else $error("small package misdecoded");

  AST_REQ_REFUSED: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_LATCH || state_q == BMRR_ST_BOOT
    |=> state_q != BMRR_ST_RUN_RST)
    else $error("running reset taken outside run");

  AST_OE_IN_RUN: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_RUN
    |-> reset_out_running_reset_in_oe && reset_out_running_reset_in_o)
    else $error("pad not driven high while running");

  AST_OE_OFF_RESET: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_RUN_RST
    |-> !reset_out_running_reset_in_oe)
    else $error("pad driven during running reset");

  AST_RUN_RST_WIDTH: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_RUN ##1 state_q == BMRR_ST_RUN_RST
    |=> state_q == BMRR_ST_RUN_RST ##1 state_q == BMRR_ST_RUN)
    else $error("running reset width wrong");

  AST_CNT_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q != BMRR_ST_RUN_RST
    |=> cnt_q == '0)
    else $error("width counter not cleared");

  AST_LATCH_ONCE: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_LATCH
    |=> state_q != BMRR_ST_LATCH)
    else $error("boot pins latched twice");

  AST_BOOT_WAITS: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_BOOT && !boot_done
    |=> state_q == BMRR_ST_BOOT)
    else $error("boot left before load finished");

  AST_BOOT_ENDS: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_BOOT && boot_done
    |=> state_q == BMRR_ST_RUN && core_rst_n)
    else $error("core not released after load");

  AST_BOOT_DOMAINS: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_BOOT
    |-> !core_rst_n && periph_rst_n && sdram_rst_n && pll_rst_n)
    else $error("reset domains wrong while loading");

  AST_START_NEEDS_SRC: assert property (@(posedge core_clk) disable iff (!nrst)
    boot_start
    |-> src_loads(src_q))
    else $error("loader started without a source");

  AST_RSVD_NO_BOOT: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_LATCH && src_dec == BMRR_SRC_RESERVED
    |=> boot_reserved && !boot_start && !rom_exec && core_rst_n)
    else $error("reserved code handled wrong");

  AST_LARGE_SLAVE: assert property (@(posedge core_clk) disable iff (!nrst)
    pkg_large && boot_select_pins_three == 3'h0
    |-> src_dec == BMRR_SRC_SPI_SLAVE)
    else $error("slave code misdecoded");

  AST_LARGE_MASTER: assert property (@(posedge core_clk) disable iff (!nrst)
    pkg_large && boot_select_pins_three == 3'h1
    |-> src_dec == BMRR_SRC_SPI_MASTER)
    else $error("master code misdecoded");

  AST_LARGE_NONE: assert property (@(posedge core_clk) disable iff (!nrst)
    pkg_large && boot_select_pins_three == 3'h3
    |-> src_dec == BMRR_SRC_NONE)
    else $error("no boot code misdecoded");

  AST_SMALL_SLAVE: assert property (@(posedge core_clk) disable iff (!nrst)
    !pkg_large && boot_select_pins_two == 2'h0
    |-> src_dec == BMRR_SRC_SPI_SLAVE)
    else $error("small slave code misdecoded");

  AST_SMALL_MASTER: assert property (@(posedge core_clk) disable iff (!nrst)
    !pkg_large && boot_select_pins_two == 2'h1
    |-> src_dec == BMRR_SRC_SPI_MASTER)
    else $error("small master code misdecoded");

  AST_RUN_STAYS: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == BMRR_ST_RUN && !run_req
    |=> state_q == BMRR_ST_RUN)
    else $error("run left without a request");

  AST_SRC_HELD: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q != BMRR_ST_LATCH
    |=> $stable(src_q))
    else $error("boot source changed after latch");
endmodule // bmrr_top

/* sim/bmrr_partner.sv */
// far side: boot loader handshake and running-reset source
`timescale 1ns/1ns
module bmrr_partner (
  input wire logic core_clk,
  input wire logic boot_start,
  input wire logic pad_o,
  input wire logic pad_oe,
  input wire logic run_req,
  output logic pad_i,
  output logic boot_done
);
  logic [1:0] cnt_q = 2'h0;
  // pad pulled low
  // undriven pad floats high through its pull-up
  assign pad_i = run_req ? 1'b0 : (pad_oe ? pad_o : 1'b1);
  // load ends a few cycles after start
  always @(posedge core_clk) begin
    cnt_q <= boot_start ? 2'h3 : (cnt_q != 2'h0 ? cnt_q - 2'h1 : 2'h0);
    boot_done <= (cnt_q == 2'h1);
  end
endmodule // bmrr_partner

/* sim/tb_top.sv */
// testbench for the boot mode and running reset block
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic pkg_large = 1'b1;
  logic run_req = 1'b0;
  logic [2:0] pins3 = 3'h0;
  logic [1:0] pins2 = 2'h0;
  logic pad_i, pad_o, pad_oe, boot_done, boot_start, boot_reserved, rom_exec;
  logic core_rst_n, periph_rst_n, pll_rst_n, sdram_rst_n;
  logic [2:0] boot_source;
  int errors = 0;
  int n_tests = 0;
  int k;
  always #25 core_clk = ~core_clk;
  bmrr_top dut (.core_clk(core_clk), .nrst(nrst), .pkg_large(pkg_large), .boot_select_pins_three(pins3),
    .boot_select_pins_two(pins2), .boot_done(boot_done), .reset_out_running_reset_in_i(pad_i),
    .reset_out_running_reset_in_o(pad_o), .reset_out_running_reset_in_oe(pad_oe), .boot_source(boot_source),
    .boot_start(boot_start), .boot_reserved(boot_reserved), .rom_exec(rom_exec), .core_rst_n(core_rst_n),
    .periph_rst_n(periph_rst_n), .pll_rst_n(pll_rst_n), .sdram_rst_n(sdram_rst_n));
  bmrr_partner far (.core_clk(core_clk), .boot_start(boot_start), .pad_o(pad_o), .pad_oe(pad_oe),
    .run_req(run_req), .pad_i(pad_i), .boot_done(boot_done));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // power-up with strapped pins held steady across release
  task automatic boot(input logic lg, input logic [2:0] code, input logic [2:0] src);
    int n;
    n = 0;
    @(posedge core_clk);
    nrst <= 1'b0;
    pkg_large <= lg;
    pins3 <= code;
    pins2 <= code[1:0];
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk({3'h0, pll_rst_n, sdram_rst_n, core_rst_n, periph_rst_n, 1'b0}, 8'h10);
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (10) begin
      @(negedge core_clk);
      n += boot_start;
    end
    chk({n[1:0], boot_reserved, rom_exec, 1'b0, boot_source},
      {1'b0, src < 3'h3, src == 3'h4, src == 3'h3, 1'b0, src});
    if (src != 3'h4)
      chk({7'h0, core_rst_n}, 8'h01);
  endtask
  // pad pulled low while driven high: short core reset, no new boot
  task automatic run_rst;
    int w;
    int n;
    w = 0;
    n = 0;
    while (pad_oe !== 1'b1 && w < 20) begin
      @(posedge core_clk);
      w++;
    end
    @(posedge core_clk);
    run_req <= 1'b1;
    @(posedge core_clk);
    run_req <= 1'b0;
    @(negedge core_clk);
    chk({3'h0, pad_oe, core_rst_n, periph_rst_n, pll_rst_n, sdram_rst_n}, 8'h03);
    repeat (4) begin
      @(negedge core_clk);
      n += boot_start;
    end
    chk({n[1:0], boot_source, core_rst_n, periph_rst_n, sdram_rst_n}, 8'h0f);
    chk({7'h0, pad_oe}, 8'h01);
  endtask
  // pad pulled low while still loading: refused, no running reset follows
  task automatic early_pull;
    int n;
    n = 0;
    @(posedge core_clk);
    nrst <= 1'b0;
    pkg_large <= 1'b1;
    pins3 <= 3'h2;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    run_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    run_req <= 1'b0;
    repeat (10) begin
      @(negedge core_clk);
      n += !periph_rst_n;
    end
    chk({n[3:0], 3'h0, core_rst_n}, 8'h01);
  endtask
  initial begin
    for (k = 0; k < 8; k++)
      boot(1'b1, k[2:0], k < 4 ? k[2:0] : 3'h4);
    for (k = 0; k < 4; k++)
      boot(1'b0, k[2:0], k == 2 ? 3'h4 : k[2:0]);
    early_pull();
    boot(1'b1, 3'h1, 3'h1);
    run_rst();
    run_rst();
    stop_test();
  end
  // whole run is a few hundred cycles; allow ample margin
  initial begin
    #100000;
    errors++;
    stop_test();
  end
endmodule // tb_top
